// ==== shared/cca_pkg.sv ====
package cca_pkg;

   // Register offsets
   localparam int          ADR_W        = 10;
   localparam logic [9:0]  ADR_AVG_CFG  = 10'h025;
   localparam logic [9:0]  ADR_ASSESS   = 10'h03a;
   localparam logic [9:0]  ADR_REQ_CTL  = 10'h03e;
   localparam logic [9:0]  ADR_ED_THR   = 10'h03f;
   localparam logic [9:0]  ADR_RESULT   = 10'h210;
   localparam logic [9:0]  ADR_IRQ_STAT = 10'h300;
   localparam logic [9:0]  ADR_IRQ_MASK = 10'h301;

   // Field positions
   localparam int MODE_LSB   = 6;
   localparam int CS_LSB     = 2;
   localparam int AVG_LSB    = 4;
   localparam int AVG_HI_LSB = 6;
   localparam int REQ_BIT    = 7;
   localparam int APP_BIT    = 6;
   localparam int RDY_BIT    = 0;

   // Interrupt bits
   localparam int IRQ_W     = 3;
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_FRAME = 1;
   localparam int IRQ_BUSY  = 2;

   // Values after reset
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_IRQ  = 3'h0;

   // Counts of symbols and chips, quality scale
   localparam int DEM_SYMS_DEF = 8;
   localparam int LQI_SYMS     = 3;
   localparam int CHIP_MAX     = 32;
   localparam int LQI_MUL      = 85;
   localparam int LQI_SHIFT    = 5;

   // Power range in dBm
   localparam logic signed [7:0] PWR_LOW  = -8'sd90;
   localparam logic signed [7:0] PWR_HIGH = -8'sd35;
   localparam logic signed [7:0] PWR_OFS  = 8'sd89;

   // Strength for -89 dBm up to -36 dBm
   localparam logic [0:53][7:0] STRENGTH_MAP = {
      8'h01, 8'h02, 8'h05, 8'h09, 8'h0d, 8'h12, 8'h17, 8'h1b, 8'h20,
      8'h25, 8'h2b, 8'h30, 8'h35, 8'h3a, 8'h3f, 8'h44, 8'h49, 8'h4e,
      8'h53, 8'h59, 8'h5f, 8'h64, 8'h6b, 8'h6f, 8'h75, 8'h79, 8'h7d,
      8'h81, 8'h85, 8'h8a, 8'h8f, 8'h94, 8'h99, 8'h9f, 8'ha5, 8'haa,
      8'hb0, 8'hb7, 8'hbc, 8'hc1, 8'hc6, 8'hcb, 8'hcf, 8'hd4, 8'hd8,
      8'hdd, 8'he1, 8'he4, 8'he9, 8'hef, 8'hf5, 8'hfa, 8'hfd, 8'hfe};

   // Assessment modes
   localparam logic [1:0] MODE_ED   = 2'b10;
   localparam logic [1:0] MODE_CS   = 2'b01;
   localparam logic [1:0] MODE_BOTH = 2'b11;

   typedef enum logic [1:0] {
      APP_IDLE = 2'b00,
      APP_LQI  = 2'b01,
      APP_STRENGTH_RESULT = 2'b11
   } cca_app_e;

   typedef struct packed {
      logic [ADR_W-1:0] addr;
      logic [7:0]       wdata;
      logic             wr;
      logic             rd;
   } cca_bus_req_s;

   typedef struct packed {
      logic       sym_tick;
      logic [7:0] power_dbm;
      logic [3:0] carrier_level;
      logic       preamble;
      logic [5:0] chip_match;
   } cca_radio_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       done;
      logic       ok;
   } cca_rx_s;

   typedef struct packed {
      logic       wr;
      logic [7:0] data;
   } cca_buf_s;

endpackage

// ==== core/cca_strength_result_lqi_unit.sv ====
// Behaviour
// - Mode 10: busy when energy exceeds threshold
// - Mode 01: busy on carrier only
// - Mode 11: busy on carrier and energy
// - Carrier threshold in assessment control 5:2
// - Eight-bit energy threshold, strength scale
// - Strength is unsigned eight bits
// - Average count field selects symbols averaged
// - Ready flag set when measurement completes
// - Result holds eight-symbol average
// - Append enable adds strength byte
// - Frame bytes, then quality, then strength
// - Map -90 dBm to 0, -35 to ff
// - Quality scaled 0 worst, 255 best
// - Quality over three preamble symbols
//
// Decided for this implementation: the address-and-strobe port.
module cca_strength_result_lqi_unit
   import cca_pkg::*;
#(
   parameter int DEM_SYMS = DEM_SYMS_DEF
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Register port
   input  wire cca_bus_req_s bus,
   output logic [7:0]        rdata,
   // Demodulator side
   input  wire cca_radio_s   radio,
   input  wire cca_rx_s      rx,
   // Receive buffer side
   output cca_buf_s          buf_out,
   // Status
   output logic              cca_busy,
   output logic              irq
);

   localparam int DEM_SH = $clog2(DEM_SYMS);

   // Only power-of-two windows up to eight fit the accumulator
   if (DEM_SYMS < 1 || DEM_SYMS > 8 || (1 << DEM_SH) != DEM_SYMS) begin : g_chk
      $error("DEM_SYMS must be 1, 2, 4 or 8");
   end

   typedef struct packed {
      logic [1:0]       avg_hi;
      logic [1:0]       avg_cnt;
      logic [1:0]       mode;
      logic [3:0]       cs_thr;
      logic             req_busy;
      logic             append_en;
      logic             ready;
      logic [7:0]       ed_thr;
      logic [7:0]       result;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic [10:0]      dem_acc;
      logic [3:0]       dem_cnt;
      logic [10:0]      ed_acc;
      logic [3:0]       ed_cnt;
      logic [7:0]       ed_level;
      logic [6:0]       lqi_acc;
      logic [1:0]       lqi_cnt;
      logic [7:0]       lqi;
      logic             pre_d;
      cca_app_e         app;
      logic [7:0]       rdata;
      logic             buf_wr;
      logic [7:0]       buf_data;
      logic             busy;
      logic             irq;
   } cca_state_s;

   cca_state_s s_ff;
   cca_state_s nxt_s;

   // Received power to strength, clamped at both ends
   function automatic logic [7:0] map_power(input logic [7:0] p);
      logic signed [7:0] ps;
      logic signed [7:0] idx;
      ps  = $signed(p);
      idx = ps + PWR_OFS;
      if (ps <= PWR_LOW) begin
         map_power = 8'h00;
      end else if (ps >= PWR_HIGH) begin
         map_power = 8'hff;
      end else begin
         map_power = STRENGTH_MAP[idx[5:0]];
      end
   endfunction

   logic [7:0]       sample;
   logic             wr_avg;
   logic             wr_assess;
   logic             wr_req;
   logic             wr_thr;
   logic             wr_stat;
   logic             wr_mask;
   logic             dem_done;
   logic [10:0]      dem_sum;
   logic [10:0]      ed_sum;
   logic [4:0]       ed_win;
   logic [5:0]       chips;
   logic [6:0]       lqi_sum;
   logic [12:0]      lqi_prod;
   logic             ed_over;
   logic             cs_hit;
   logic             busy_now;
   logic [IRQ_W-1:0] ev;

   // Decode and datapath terms
   always_comb begin
      sample    = map_power(radio.power_dbm);
      wr_avg    = bus.wr && (bus.addr == ADR_AVG_CFG);
      wr_assess = bus.wr && (bus.addr == ADR_ASSESS);
      wr_req    = bus.wr && (bus.addr == ADR_REQ_CTL) && bus.wdata[REQ_BIT];
      wr_thr    = bus.wr && (bus.addr == ADR_ED_THR);
      wr_stat   = bus.wr && (bus.addr == ADR_IRQ_STAT);
      wr_mask   = bus.wr && (bus.addr == ADR_IRQ_MASK);
      dem_sum   = s_ff.dem_acc + 11'(sample);
      dem_done  = s_ff.req_busy && radio.sym_tick && (s_ff.dem_cnt == 4'(DEM_SYMS - 1));
      ed_sum    = s_ff.ed_acc + 11'(sample);
      ed_win    = 5'd1 << s_ff.avg_cnt;
      chips     = (radio.chip_match > 6'(CHIP_MAX)) ? 6'(CHIP_MAX) : radio.chip_match;
      lqi_sum   = s_ff.lqi_acc + 7'(chips);
      lqi_prod  = 13'(lqi_sum) * 13'(LQI_MUL);
      ed_over   = s_ff.ed_level > s_ff.ed_thr;
      cs_hit    = radio.carrier_level > s_ff.cs_thr;
      case (s_ff.mode)
         MODE_ED:   busy_now = ed_over;
         MODE_CS:   busy_now = cs_hit;
         MODE_BOTH: busy_now = cs_hit && ed_over;
         default:   busy_now = 1'b0;
      endcase
      ev            = '0;
      ev[IRQ_DONE]  = dem_done;
      ev[IRQ_BUSY]  = busy_now && !s_ff.busy;
      ev[IRQ_FRAME] = (s_ff.app == APP_STRENGTH_RESULT) ||
                      ((s_ff.app == APP_LQI) && !s_ff.append_en);
   end

   // Next state
   always_comb begin
      nxt_s        = s_ff;
      nxt_s.buf_wr = 1'b0;
      nxt_s.busy   = busy_now;

      // Configuration writes
      if (wr_avg) begin
         nxt_s.avg_hi  = bus.wdata[AVG_HI_LSB +: 2];
         nxt_s.avg_cnt = bus.wdata[AVG_LSB +: 2];
      end
      if (wr_assess) begin
         nxt_s.mode   = bus.wdata[MODE_LSB +: 2];
         nxt_s.cs_thr = bus.wdata[CS_LSB +: 4];
      end
      if (wr_thr) begin
         nxt_s.ed_thr = bus.wdata;
      end
      if (bus.wr && (bus.addr == ADR_REQ_CTL)) begin
         nxt_s.append_en = bus.wdata[APP_BIT];
      end
      if (wr_mask) begin
         nxt_s.irq_mask = bus.wdata[IRQ_W-1:0];
      end

      // On-demand measurement over a fixed window of symbols
      if (s_ff.req_busy && radio.sym_tick) begin
         nxt_s.dem_acc = dem_sum;
         nxt_s.dem_cnt = s_ff.dem_cnt + 4'd1;
      end
      if (dem_done) begin
         nxt_s.result   = 8'(dem_sum >> DEM_SH);
         nxt_s.req_busy = 1'b0;
      end
      // A new request restarts the window
      if (wr_req) begin
         nxt_s.req_busy = 1'b1;
         nxt_s.dem_acc  = '0;
         nxt_s.dem_cnt  = '0;
      end
      // Completion in the same cycle as a request keeps the flag
      nxt_s.ready = (s_ff.ready && !wr_req) || dem_done;

      // Running energy average feeding assessment and the appended byte
      if (radio.sym_tick) begin
         if (5'(s_ff.ed_cnt) + 5'd1 >= ed_win) begin
            nxt_s.ed_level = 8'(ed_sum >> s_ff.avg_cnt);
            nxt_s.ed_acc   = '0;
            nxt_s.ed_cnt   = '0;
         end else begin
            nxt_s.ed_acc = ed_sum;
            nxt_s.ed_cnt = s_ff.ed_cnt + 4'd1;
         end
      end

      // Quality from chip correlation at the start of the preamble
      nxt_s.pre_d = radio.preamble;
      if (radio.preamble && !s_ff.pre_d) begin
         nxt_s.lqi_acc = '0;
         nxt_s.lqi_cnt = '0;
      end else if (radio.preamble && radio.sym_tick && (s_ff.lqi_cnt < 2'(LQI_SYMS))) begin
         nxt_s.lqi_acc = lqi_sum;
         nxt_s.lqi_cnt = s_ff.lqi_cnt + 2'd1;
         if (s_ff.lqi_cnt == 2'(LQI_SYMS - 1)) begin
            nxt_s.lqi = 8'(lqi_prod >> LQI_SHIFT);
         end
      end

      // Frame bytes pass through, trailer added after a good frame
      case (s_ff.app)
         APP_IDLE: begin
            if (rx.valid) begin
               nxt_s.buf_wr   = 1'b1;
               nxt_s.buf_data = rx.data;
            end
            if (rx.done && rx.ok) begin
               nxt_s.app = APP_LQI;
            end
         end
         APP_LQI: begin
            nxt_s.buf_wr   = 1'b1;
            nxt_s.buf_data = s_ff.lqi;
            nxt_s.app      = s_ff.append_en ? APP_STRENGTH_RESULT : APP_IDLE;
         end
         APP_STRENGTH_RESULT: begin
            nxt_s.buf_wr   = 1'b1;
            nxt_s.buf_data = s_ff.ed_level;
            nxt_s.app      = APP_IDLE;
         end
         default: begin
            nxt_s.app = APP_IDLE;
         end
      endcase

      // Sticky events: a set beats a clear in the same cycle
      nxt_s.irq_stat = (s_ff.irq_stat & ~(wr_stat ? bus.wdata[IRQ_W-1:0] : '0)) | ev;
      nxt_s.irq      = |(nxt_s.irq_stat & nxt_s.irq_mask);

      // Read data stands in the cycle after the strobe only
      nxt_s.rdata = 8'h00;
      if (bus.rd) begin
         case (bus.addr)
            ADR_AVG_CFG:  nxt_s.rdata = {s_ff.avg_hi, s_ff.avg_cnt, 4'h0};
            ADR_ASSESS:   nxt_s.rdata = {s_ff.mode, s_ff.cs_thr, 2'b00};
            ADR_REQ_CTL:  nxt_s.rdata = {s_ff.req_busy, s_ff.append_en, 5'h00, s_ff.ready};
            ADR_ED_THR:   nxt_s.rdata = s_ff.ed_thr;
            ADR_RESULT:   nxt_s.rdata = s_ff.result;
            ADR_IRQ_STAT: nxt_s.rdata = 8'(s_ff.irq_stat);
            ADR_IRQ_MASK: nxt_s.rdata = 8'(s_ff.irq_mask);
            default:      nxt_s.rdata = 8'h00;
         endcase
      end
   end

   // State register; clock enable low freezes everything
   always_ff @(posedge clk) begin
      if (rst) begin
         s_ff          <= '0;
         s_ff.ed_thr   <= RST_BYTE;
         s_ff.result   <= RST_BYTE;
         s_ff.irq_stat <= RST_IRQ;
         s_ff.irq_mask <= RST_IRQ;
         s_ff.app      <= APP_IDLE;
      end else if (ce) begin
         s_ff <= nxt_s;
      end
   end

   // Outputs straight from the state register
   assign rdata        = s_ff.rdata;
   assign buf_out.wr   = s_ff.buf_wr;
   assign buf_out.data = s_ff.buf_data;
   assign cca_busy     = s_ff.busy;
   assign irq          = s_ff.irq;

endmodule // cca_strength_result_lqi_unit

// ==== tb/cca_checker_sva.sv ====
module cca_checker
   import cca_pkg::*;
(
   // Clock and reset
   input wire logic         clk,
   input wire logic         rst,
   input wire logic         ce,
   // Register port
   input wire cca_bus_req_s bus,
   input wire logic [7:0]   rdata,
   // Radio and frame side
   input wire cca_radio_s   radio,
   input wire cca_rx_s      rx,
   input wire cca_buf_s     buf_out,
   // Status
   input wire logic         cca_busy,
   input wire logic         irq
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0] assess_ff;
   logic [7:0] req_ff;
   logic [7:0] mask_ff;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Shadow host writes, so checks know the mode without peeking inside
   always_ff @(posedge clk) begin
      if (rst) begin
         assess_ff <= 8'h00;
         req_ff    <= 8'h00;
         mask_ff   <= 8'h00;
      end else if (ce && bus.wr) begin
         if (bus.addr == ADR_ASSESS) assess_ff <= bus.wdata;
         if (bus.addr == ADR_REQ_CTL) req_ff <= bus.wdata;
         if (bus.addr == ADR_IRQ_MASK) mask_ff <= bus.wdata;
      end
   end

   // Write, one idle cycle, read back through the field mask
   property p_readback(a, m);
      bus.wr && bus.addr == a ##2 bus.rd && bus.addr == a |=> rdata == ($past(bus.wdata, 3) & m);
   endproperty

   a_carrier_mode: assert property (assess_ff[7:6] == MODE_CS |=>
      cca_busy == ($past(radio.carrier_level) > $past(assess_ff[5:2]))) else $error("carrier mode busy wrong");
   a_both_need_carrier: assert property (assess_ff[7:6] == MODE_BOTH &&
      radio.carrier_level <= assess_ff[5:2] |=> !cca_busy) else $error("busy without carrier");
   a_byte_forward: assert property (rx.valid && !$past(rx.done) && !$past(rx.done, 2) &&
      !$past(rx.done, 3) |=> buf_out.wr && buf_out.data == $past(rx.data)) else $error("frame byte lost");
   a_quality_slot: assert property (rx.done |-> ##2 buf_out.wr == $past(rx.ok, 2))
      else $error("quality byte slot wrong");
   a_strength_slot: assert property (rx.done && rx.ok |-> ##3 buf_out.wr == $past(req_ff[APP_BIT], 3))
      else $error("strength byte slot wrong");
   a_request_clears: assert property (bus.wr && bus.addr == ADR_REQ_CTL && bus.wdata[REQ_BIT] ##2
      bus.rd && bus.addr == ADR_REQ_CTL |=> !rdata[RDY_BIT] && rdata[REQ_BIT]) else $error("stale ready");
   a_thr_readback: assert property (p_readback(ADR_ED_THR, 8'hff)) else $error("threshold readback");
   a_cs_readback: assert property (p_readback(ADR_ASSESS, 8'hfc)) else $error("assess readback");
   a_count_readback: assert property (p_readback(ADR_AVG_CFG, 8'hf0)) else $error("count readback");
   a_irq_masked: assert property (mask_ff[2:0] == 3'h0 ##1 mask_ff[2:0] == 3'h0 |-> !irq)
      else $error("irq while masked");
   a_rdata_idle: assert property (ce && !bus.rd |=> rdata == 8'h00)
      else $error("read data outside its cycle");

   c_result_read: cover property (bus.rd && bus.addr == ADR_RESULT);
   c_busy_rise: cover property ($rose(cca_busy));
   c_trailer: cover property (rx.done && rx.ok ##3 buf_out.wr);
endmodule // cca_checker

// ==== tb/cca_host_model.sv ====
module cca_host_model
   import cca_pkg::*;
(
   // Clock
   input wire logic       clk,
   // Register port
   output cca_bus_req_s   bus,
   input wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   initial bus = '0;

   // One-cycle write; an idle edge first keeps strobes from merging
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
      d = rdata;
   endtask
endmodule // cca_host_model

// ==== tb/cca_strength_result_lqi_unit_test.sv ====
module cca_strength_result_lqi_unit_test import cca_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;

   logic              clk, rst, ce, cca_busy, irq, e;
   logic [7:0]        rdata, v, got[$], want[$];
   logic [1:0]        ph = 2'd0;
   logic signed [7:0] pw;
   cca_bus_req_s      bus;
   cca_radio_s        radio;
   cca_rx_s           rx;
   cca_buf_s          buf_out;
   int                seed = 67, n_mismatch = 0, n_compared = 0, n, c;
   localparam logic [9:0] ADRS [7] = '{ADR_AVG_CFG, ADR_ASSESS, ADR_ED_THR, ADR_IRQ_MASK,
                                       ADR_RESULT, ADR_IRQ_STAT, 10'h155};
   localparam logic [7:0] MSK [7] = '{8'hf0, 8'hfc, 8'hff, 8'h07, 8'h00, 8'h00, 8'h00};
   localparam logic signed [7:0] PW_T [4] = '{-8'sd90, -8'sd89, -8'sd36, -8'sd35};

   cca_strength_result_lqi_unit cca_strength_result_lqi_unit_inst (.clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
      .radio(radio), .rx(rx), .buf_out(buf_out), .cca_busy(cca_busy), .irq(irq));
   cca_host_model cca_host_model_inst (.clk(clk), .bus(bus), .rdata(rdata));

   // Expected strength from the power table, clamped at both ends
   function automatic logic [7:0] to_strength(input logic signed [7:0] p);
      if (p <= PWR_LOW) return 8'h00;
      if (p >= PWR_HIGH) return 8'hff;
      return STRENGTH_MAP[int'(p + PWR_OFS)];
   endfunction

   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      n_compared++;
      if (g !== x) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask

   task automatic tally_and_finish;
      if (n_mismatch == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Symbol tick every fourth cycle
   always @(posedge clk) begin
      ph <= ph + 2'd1;
      radio.sym_tick <= (ph == 2'd3);
   end

   // Collect buffer writes where they are settled
   always @(negedge clk) if (buf_out.wr) got.push_back(buf_out.data);

   // Watchdog well beyond the thousand or so cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      tally_and_finish;
   end

   initial begin
      ce = 1'b1;
      rst = 1'b1;
      rx = '0;
      radio = '0;
      radio.power_dbm = -8'sd100;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values, field masks, read-only and unmapped places
      foreach (ADRS[i]) begin
         cca_host_model_inst.rd(ADRS[i], v);
         chk(v, RST_BYTE);
         n = $random(seed);
         cca_host_model_inst.wr(ADRS[i], n[7:0]);
         cca_host_model_inst.rd(ADRS[i], v);
         chk(v, n[7:0] & MSK[i]);
      end
      cca_host_model_inst.wr(ADR_AVG_CFG, 8'h00);
      cca_host_model_inst.wr(ADR_ASSESS, 8'h00);
      cca_host_model_inst.wr(ADR_IRQ_MASK, 8'h00);
      // On-demand measurement at table corners, then random powers
      for (int i = 0; i < 8; i++) begin
         n = $random(seed) & 63;
         pw = (i < 4) ? PW_T[i] : -8'sd95 + 8'(n);
         radio.power_dbm <= pw;
         cca_host_model_inst.wr(ADR_IRQ_STAT, 8'h07);
         cca_host_model_inst.wr(ADR_REQ_CTL, 8'h80);
         // Clock enable low must freeze the window, so the request still stands
         if (i == 0) begin
            ce <= 1'b0;
            repeat (40) @(posedge clk);
            ce <= 1'b1;
         end
         cca_host_model_inst.rd(ADR_REQ_CTL, v);
         chk(v, 8'h80);
         for (int k = 0; k < 20 && v[0] !== 1'b1; k++) cca_host_model_inst.rd(ADR_REQ_CTL, v);
         chk(v, 8'h01);
         cca_host_model_inst.rd(ADR_RESULT, v);
         chk(v, to_strength(pw));
         cca_host_model_inst.rd(ADR_IRQ_STAT, v);
         chk(v, 8'h01);
         @(negedge clk) chk({7'h0, irq}, 8'h00);
         cca_host_model_inst.wr(ADR_IRQ_MASK, 8'h01);
         repeat (2) @(negedge clk);
         chk({7'h0, irq}, 8'h01);
         cca_host_model_inst.wr(ADR_IRQ_STAT, 8'h01);
         repeat (2) @(negedge clk);
         chk({7'h0, irq}, 8'h00);
         cca_host_model_inst.wr(ADR_IRQ_MASK, 8'h00);
      end
      // Every assessment mode against strong and weak energy, random carrier
      for (int m = 0; m < 4; m++) begin
         for (int p = 0; p < 4; p++) begin
            @(posedge clk);
            n = $random(seed);
            radio.power_dbm <= p[0] ? -8'sd30 : -8'sd100;
            radio.carrier_level <= n[3:0];
            cca_host_model_inst.wr(ADR_ASSESS, {m[1:0], n[7:4], 2'b00});
            cca_host_model_inst.wr(ADR_ED_THR, {1'b0, n[14:8]});
            repeat (6) @(negedge clk);
            e = (m != 0) && (!m[1] || p[0]) && (!m[0] || n[3:0] > n[7:4]);
            chk({7'h0, cca_busy}, {7'h0, e});
         end
      end
      // Eight-symbol energy window: busy lags a power step, then rises once
      cca_host_model_inst.wr(ADR_AVG_CFG, 8'h30);
      radio.power_dbm <= -8'sd100;
      cca_host_model_inst.wr(ADR_ED_THR, 8'h7f);
      cca_host_model_inst.wr(ADR_ASSESS, 8'h80);
      repeat (80) @(posedge clk);
      cca_host_model_inst.wr(ADR_IRQ_STAT, 8'h07);
      radio.power_dbm <= -8'sd30;
      repeat (8) @(negedge clk);
      chk({7'h0, cca_busy}, 8'h00);
      repeat (80) @(negedge clk);
      chk({7'h0, cca_busy}, 8'h01);
      cca_host_model_inst.rd(ADR_IRQ_STAT, v);
      chk(v, 8'h04);
      cca_host_model_inst.wr(ADR_AVG_CFG, 8'h00);
      // Frames with and without trailer byte; the last one fails its check
      cca_host_model_inst.wr(ADR_ASSESS, 8'h00);
      radio.power_dbm <= -8'sd60;
      for (int f = 0; f < 4; f++) begin
         n = $random(seed);
         c = (f == 0) ? 32 : (f == 2) ? 40 : n[4:0];
         cca_host_model_inst.wr(ADR_IRQ_STAT, 8'h07);
         cca_host_model_inst.wr(ADR_REQ_CTL, {1'b0, f[0], 6'h00});
         radio.chip_match <= 6'(c);
         radio.preamble <= 1'b1;
         repeat (14) @(posedge clk);
         radio.preamble <= 1'b0;
         got.delete();
         want.delete();
         for (int b = 0; b < 4; b++) begin
            v = $random(seed);
            want.push_back(v);
            rx <= '{1'b1, v, b == 3, f < 3};
            @(posedge clk);
         end
         rx <= '0;
         repeat (6) @(posedge clk);
         if (f < 3) want.push_back(8'(((c > 32 ? 32 : c) * 255) / 32));
         if (f == 1) want.push_back(8'h8a);
         chk(8'(got.size()), 8'(want.size()));
         foreach (want[i]) chk(got[i], want[i]);
         cca_host_model_inst.rd(ADR_IRQ_STAT, v);
         chk(v, (f < 3) ? 8'h02 : 8'h00);
      end
      tally_and_finish;
   end
endmodule // cca_strength_result_lqi_unit_test

bind cca_strength_result_lqi_unit cca_checker cca_checker_inst (.clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
   .radio(radio), .rx(rx), .buf_out(buf_out), .cca_busy(cca_busy), .irq(irq));
